// ==== common/sts_pkg.sv ====
`default_nettype none
package sts_pkg;

  // Clock and converter sampling rate
  localparam int CLK_HZ           = 100_000_000;
  localparam int SAMPLE_HZ        = 500_000;
  localparam int SAMPLE_DIV       = CLK_HZ / SAMPLE_HZ;
  localparam int SAMPLE_PERIOD_NS = 1_000_000_000 / SAMPLE_HZ;

  // Selectable conversion times, in ns, indexed by the 3-bit time code
  localparam int CT0_NS = 140_000;
  localparam int CT1_NS = 204_000;
  localparam int CT2_NS = 332_000;
  localparam int CT3_NS = 588_000;
  localparam int CT4_NS = 1_100_000;
  localparam int CT5_NS = 2_116_000;
  localparam int CT6_NS = 4_156_000;
  localparam int CT7_NS = 8_244_000;
  localparam int CT_TICKS_W = 13;
  localparam int CT7_TICKS  = (CT7_NS + SAMPLE_PERIOD_NS - 1) / SAMPLE_PERIOD_NS;

  // Fixed steps: bus 1.25 mV, shunt 2.5 uV per code
  localparam int BUS_STEP_UV   = 1250;
  localparam int SHUNT_STEP_NV = 2500;
  // 0.00512 divided by the 2.5 uV shunt step gives 2048
  localparam int CAL_SHIFT     = 11;
  localparam int POWER_RATIO   = 25;
  localparam int POWER_DIV     = POWER_RATIO * 1_000_000 / BUS_STEP_UV;
  localparam int RECIP_SHIFT   = 30;
  localparam int POWER_RECIP   = ((2 ** RECIP_SHIFT) + POWER_DIV / 2) / POWER_DIV;

  // Converter setup word layout and default
  localparam int          CFG_MODE_LSB  = 0;
  localparam int          CFG_SHUNT_LSB = 3;
  localparam int          CFG_BUS_LSB   = 6;
  localparam int          CFG_AVG_LSB   = 9;
  localparam logic [15:0] CFG_RESET     = 16'h4127;
  localparam logic [15:0] CAL_RESET     = 16'h0001;
  localparam int          CAL_BITS      = 15;

  // Threshold comparisons use the top bits only
  localparam int WARN_LSB = 4;
  localparam int ACC_W    = 28;

  typedef enum logic [2:0] {
    STS_IDLE, STS_SHUNT, STS_CURR, STS_BUS, STS_POWER, STS_ACC, STS_LOAD
  } sts_state_t;

  function automatic logic [CT_TICKS_W-1:0] ct_ticks(input logic [2:0] code,
                                                     input int t7);
    int ns;
    case (code)
      3'h0:    ns = CT0_NS;
      3'h1:    ns = CT1_NS;
      3'h2:    ns = CT2_NS;
      3'h3:    ns = CT3_NS;
      3'h4:    ns = CT4_NS;
      3'h5:    ns = CT5_NS;
      3'h6:    ns = CT6_NS;
      default: ns = 0;
    endcase
    if (code == 3'h7) return CT_TICKS_W'(t7);
    return CT_TICKS_W'((ns + SAMPLE_PERIOD_NS - 1) / SAMPLE_PERIOD_NS);
  endfunction

  // Averaging counts 1,4,16,64,128,256,512,1024 as shifts
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0:    return 4'h0;
      3'h1:    return 4'h2;
      3'h2:    return 4'h4;
      3'h3:    return 4'h6;
      3'h4:    return 4'h7;
      3'h5:    return 4'h8;
      3'h6:    return 4'h9;
      default: return 4'ha;
    endcase
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
    if (v > 64'sh7fff) return 16'sh7fff;
    if (v < -64'sh8000) return -16'sh8000;
    return v[15:0];
  endfunction

endpackage
`default_nettype wire

// ==== design/sts_top.sv ====
// How it works
// - No current or power before calibration loaded
// - Current uses fixed 0.00512 internal scaling constant
// - Power step is 25 current steps
// - Bus 1.25 mV, shunt 2.5 uV steps
// - Values are 16-bit two's complement words
// - Warnings compare upper 12 threshold bits only
// - Results carry sixteen significant converter bits
// - Settings volatile, defaults restored at reset
// - Continuous shunt and bus conversion after reset
// - New calibration applies to following measurements
// - Shunt time, bus time, averaging independent
// - Times include 4.156 ms and 588 us
// - Front end samples at 500 kHz
// - Ready flag only after all work done
// - Accumulate samples, load outputs after averaging
`timescale 1ns/10ps
`default_nettype none
module sts_top #(
  parameter int CT7_TICKS = sts_pkg::CT7_TICKS
) (
  input  wire logic        mclk_i,           // 100 MHz clock
  input  wire logic        rst_i,            // Async reset, active high
  input  wire logic [15:0] shunt_code_i,     // Converter shunt result
  input  wire logic [15:0] rail_code_i,      // Converter rail_sense_input result
  input  wire logic        setup_wr_i,       // Write converter_setup
  input  wire logic [15:0] setup_data_i,     // converter_setup value
  input  wire logic        cal_wr_i,         // Write gain_scaling_word
  input  wire logic [15:0] cal_data_i,       // gain_scaling_word value
  input  wire logic        ready_clr_i,      // Status read clears ready
  input  wire logic [15:0] oc_limit_i,       // Overcurrent threshold
  input  wire logic [15:0] ov_limit_i,       // Rail overvoltage threshold
  input  wire logic [15:0] uv_limit_i,       // Rail undervoltage threshold
  input  wire logic [15:0] op_limit_i,       // Overpower threshold
  output logic      [15:0] setup_o,          // converter_setup readback
  output logic      [15:0] cal_o,            // gain_scaling_word readback
  output logic      [15:0] sense_drop_reading_o, // Averaged shunt
  output logic      [15:0] rail_o,           // Averaged rail
  output logic      [15:0] current_o,        // Averaged current
  output logic      [15:0] power_o,          // Averaged power
  output logic      [31:0] energy_o,         // Running power sum
  output logic             ready_o,          // Conversion ready flag
  output logic             cal_loaded_o,     // Calibration written
  output logic             busy_o,           // Sequence active
  output logic             oc_warn_o,        // Overcurrent warning
  output logic             ov_warn_o,        // Overvoltage warning
  output logic             uv_warn_o,        // Undervoltage warning
  output logic             op_warn_o         // Overpower warning
);

  localparam int DIV_W = $clog2(sts_pkg::SAMPLE_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(sts_pkg::SAMPLE_DIV - 1);

  sts_pkg::sts_state_t state_q;
  logic [DIV_W-1:0]              div_q;
  logic                          tick_q;
  logic [sts_pkg::CT_TICKS_W-1:0] conv_cnt_q;
  logic [10:0]                   avg_cnt_q;
  logic                          trig_q;
  logic signed [15:0]            shunt_q, rail_q, cur_q, pwr_q;
  logic signed [sts_pkg::ACC_W-1:0] acc_sh_q, acc_rl_q, acc_cu_q, acc_pw_q;

  logic [2:0] mode, sh_ct, bus_ct, avg_code;
  logic [3:0] shift;
  logic       pd_write, run_cont, do_shunt, do_bus, restart, conv_done;
  logic [sts_pkg::CT_TICKS_W-1:0] ct_lim;
  logic signed [63:0] cur_prod, pwr_prod;
  logic [10:0] avg_last;

  assign mode     = setup_o[sts_pkg::CFG_MODE_LSB +: 3];
  assign sh_ct    = setup_o[sts_pkg::CFG_SHUNT_LSB +: 3];
  assign bus_ct   = setup_o[sts_pkg::CFG_BUS_LSB +: 3];
  assign avg_code = setup_o[sts_pkg::CFG_AVG_LSB +: 3];
  assign shift    = sts_pkg::avg_shift(avg_code);
  assign avg_last = 11'((32'h1 << shift) - 32'h1);
  assign do_shunt = mode[0];
  assign do_bus   = mode[1];
  assign run_cont = mode[2] && (mode[1:0] != 2'h0);
  assign pd_write = setup_wr_i && (setup_data_i[sts_pkg::CFG_MODE_LSB +: 2] == 2'h0);
  assign restart  = setup_wr_i;
  // Each channel counts its own time code
  assign ct_lim   = (state_q == sts_pkg::STS_SHUNT) ? sts_pkg::ct_ticks(sh_ct, CT7_TICKS)
                                                    : sts_pkg::ct_ticks(bus_ct, CT7_TICKS);
  assign conv_done = tick_q && (conv_cnt_q >= ct_lim - 1'b1);

  // Shunt code times gain word, normalised by 2048
  assign cur_prod = (64'(shunt_q) * $signed({49'h0, cal_o[sts_pkg::CAL_BITS-1:0]}))
                    >>> sts_pkg::CAL_SHIFT;
  // Current times rail over 20000 gives 25x current step
  assign pwr_prod = (64'(cur_q) * $signed({48'h0, rail_q}) * 64'(sts_pkg::POWER_RECIP))
                    >>> sts_pkg::RECIP_SHIFT;

  // 500 kHz sample enable
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == DIV_LAST);
      div_q  <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
    end
  end

  // Volatile setup and gain word, defaults at every reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      setup_o      <= sts_pkg::CFG_RESET;
      cal_o        <= sts_pkg::CAL_RESET;
      cal_loaded_o <= 1'b0;
    end else begin
      if (setup_wr_i) begin
        setup_o <= setup_data_i;
      end
      if (cal_wr_i) begin
        cal_o        <= cal_data_i;
        cal_loaded_o <= 1'b1;
      end
    end
  end

  // One-shot request from a triggered-mode write
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_q <= 1'b0;
    end else if (setup_wr_i) begin
      trig_q <= !setup_data_i[sts_pkg::CFG_MODE_LSB + 2] &&
                (setup_data_i[sts_pkg::CFG_MODE_LSB +: 2] != 2'h0);
    end else if (state_q == sts_pkg::STS_IDLE) begin
      trig_q <= 1'b0;
    end
  end

  // Measurement sequence
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= sts_pkg::STS_IDLE;
      conv_cnt_q <= '0;
      avg_cnt_q  <= '0;
      shunt_q    <= '0;
      rail_q     <= '0;
      cur_q      <= '0;
      pwr_q      <= '0;
      acc_sh_q   <= '0;
      acc_rl_q   <= '0;
      acc_cu_q   <= '0;
      acc_pw_q   <= '0;
    end else if (restart) begin
      // A new setup drops the partial average
      state_q   <= sts_pkg::STS_IDLE;
      avg_cnt_q <= '0;
      acc_sh_q  <= '0;
      acc_rl_q  <= '0;
      acc_cu_q  <= '0;
      acc_pw_q  <= '0;
    end else begin
      case (state_q)
        sts_pkg::STS_IDLE: begin
          conv_cnt_q <= '0;
          if (run_cont || trig_q) begin
            state_q <= do_shunt ? sts_pkg::STS_SHUNT : sts_pkg::STS_BUS;
          end
        end
        sts_pkg::STS_SHUNT: begin
          if (tick_q) begin
            conv_cnt_q <= conv_cnt_q + 1'b1;
          end
          if (conv_done) begin
            conv_cnt_q <= '0;
            shunt_q    <= shunt_code_i;
            state_q    <= sts_pkg::STS_CURR;
          end
        end
        sts_pkg::STS_CURR: begin
          // Live gain word, so a new one scales the next sample
          cur_q   <= cal_loaded_o ? sts_pkg::sat16(cur_prod) : 16'sh0000;
          state_q <= do_bus ? sts_pkg::STS_BUS : sts_pkg::STS_POWER;
        end
        sts_pkg::STS_BUS: begin
          if (tick_q) begin
            conv_cnt_q <= conv_cnt_q + 1'b1;
          end
          if (conv_done) begin
            conv_cnt_q <= '0;
            rail_q     <= rail_code_i;
            state_q    <= sts_pkg::STS_POWER;
          end
        end
        sts_pkg::STS_POWER: begin
          pwr_q   <= cal_loaded_o ? sts_pkg::sat16(pwr_prod) : 16'sh0000;
          state_q <= sts_pkg::STS_ACC;
        end
        sts_pkg::STS_ACC: begin
          acc_sh_q  <= acc_sh_q + sts_pkg::ACC_W'(shunt_q);
          acc_rl_q  <= acc_rl_q + sts_pkg::ACC_W'(rail_q);
          acc_cu_q  <= acc_cu_q + sts_pkg::ACC_W'(cur_q);
          acc_pw_q  <= acc_pw_q + sts_pkg::ACC_W'(pwr_q);
          avg_cnt_q <= avg_cnt_q + 1'b1;
          if (avg_cnt_q == avg_last) begin
            state_q <= sts_pkg::STS_LOAD;
          end else begin
            state_q <= do_shunt ? sts_pkg::STS_SHUNT : sts_pkg::STS_BUS;
          end
        end
        sts_pkg::STS_LOAD: begin
          avg_cnt_q <= '0;
          acc_sh_q  <= '0;
          acc_rl_q  <= '0;
          acc_cu_q  <= '0;
          acc_pw_q  <= '0;
          state_q   <= sts_pkg::STS_IDLE;
        end
        default: state_q <= sts_pkg::STS_IDLE;
      endcase
    end
  end

  // Outputs change only once the whole average is
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sense_drop_reading_o <= '0;
      rail_o               <= '0;
      current_o            <= '0;
      power_o              <= '0;
      energy_o             <= '0;
    end else if (state_q == sts_pkg::STS_LOAD && !restart) begin
      sense_drop_reading_o <= 16'(acc_sh_q >>> shift);
      rail_o               <= 16'(acc_rl_q >>> shift);
      current_o            <= 16'(acc_cu_q >>> shift);
      power_o              <= 16'(acc_pw_q >>> shift);
      energy_o             <= energy_o + 32'(16'(acc_pw_q >>> shift));
    end
  end

  // Ready: set after load, set beats a status-read clear; a setup write blocks the set
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else if (state_q == sts_pkg::STS_LOAD && !restart) begin
      ready_o <= 1'b1;
    end else if (ready_clr_i || (setup_wr_i && !pd_write)) begin
      ready_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_q != sts_pkg::STS_IDLE);
    end
  end

  // Only bits 15:4 of result and limit are compared
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_warn_o <= 1'b0;
      ov_warn_o <= 1'b0;
      uv_warn_o <= 1'b0;
      op_warn_o <= 1'b0;
    end else begin
      oc_warn_o <= $signed(current_o[15:sts_pkg::WARN_LSB]) >
                   $signed(oc_limit_i[15:sts_pkg::WARN_LSB]);
      ov_warn_o <= $signed(rail_o[15:sts_pkg::WARN_LSB]) >
                   $signed(ov_limit_i[15:sts_pkg::WARN_LSB]);
      uv_warn_o <= $signed(rail_o[15:sts_pkg::WARN_LSB]) <
                   $signed(uv_limit_i[15:sts_pkg::WARN_LSB]);
      op_warn_o <= $signed(power_o[15:sts_pkg::WARN_LSB]) >
                   $signed(op_limit_i[15:sts_pkg::WARN_LSB]);
    end
  end

endmodule // sts_top
`default_nettype wire

// ==== sim/sts_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module sts_checker #(
  parameter int CT7_TICKS = sts_pkg::CT7_TICKS
) (
  input wire logic        mclk_i,       // Clock
  input wire logic        rst_i,        // Reset
  input wire logic        setup_wr_i,   // Setup strobe
  input wire logic [15:0] setup_data_i, // Setup word
  input wire logic        cal_wr_i,     // Gain strobe
  input wire logic [15:0] cal_data_i,   // Gain word
  input wire logic [15:0] oc_limit_i,   // Current limit
  input wire logic [15:0] uv_limit_i,   // Undervoltage limit
  input wire logic [15:0] setup_o,      // Setup readback
  input wire logic [15:0] cal_o,        // Gain readback
  input wire logic [15:0] rail_o,       // Rail result
  input wire logic [15:0] current_o,    // Current result
  input wire logic [15:0] power_o,      // Power result
  input wire logic [31:0] energy_o,     // Energy sum
  input wire logic        ready_o,      // Ready flag
  input wire logic        cal_loaded_o, // Gain loaded
  input wire logic        busy_o,       // Busy
  input wire logic        oc_warn_o,    // Current warning
  input wire logic        uv_warn_o     // Undervoltage warning
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_setup; setup_wr_i |=> setup_o == $past(setup_data_i); endproperty
  a_setup: assert property (p_setup) else $error("setup readback wrong");
  property p_cal; cal_wr_i |=> cal_o[14:0] == $past(cal_data_i[14:0]) && cal_loaded_o; endproperty
  a_cal: assert property (p_cal) else $error("gain word not taken");
  property p_nocal; !cal_loaded_o |-> current_o == 16'h0000 && power_o == 16'h0000; endproperty
  a_nocal: assert property (p_nocal) else $error("result without gain word");
  property p_rdy; $rose(ready_o) |-> $past(busy_o); endproperty
  a_rdy: assert property (p_rdy) else $error("ready without sequence");
  property p_hold; $changed(rail_o) || $changed(current_o) || $changed(energy_o) |-> ready_o; endproperty
  a_hold: assert property (p_hold) else $error("result moved outside load");
  property p_oc; oc_warn_o == ($signed($past(current_o[15:4])) > $signed($past(oc_limit_i[15:4]))); endproperty
  a_oc: assert property (p_oc) else $error("current warning wrong");
  property p_uv; uv_warn_o == ($signed($past(rail_o[15:4])) < $signed($past(uv_limit_i[15:4]))); endproperty
  a_uv: assert property (p_uv) else $error("undervoltage warning wrong");
  property p_pw; setup_wr_i && setup_data_i[1:0] != 2'h0 |=> !ready_o; endproperty
  a_pw: assert property (p_pw) else $error("setup write kept ready");
endmodule // sts_checker

bind sts_top sts_checker #(.CT7_TICKS(CT7_TICKS)) i_sts_checker (.mclk_i, .rst_i, .setup_wr_i,
  .setup_data_i, .cal_wr_i, .cal_data_i, .oc_limit_i, .uv_limit_i, .setup_o, .cal_o, .rail_o,
  .current_o, .power_o, .energy_o, .ready_o, .cal_loaded_o, .busy_o, .oc_warn_o, .uv_warn_o);
`default_nettype wire

// ==== sim/sts_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module sts_host (
  input  wire logic        mclk_i,  // Device clock
  output logic             swr_o,   // Setup strobe
  output logic      [15:0] sdat_o,  // Setup word
  output logic             cwr_o,   // Gain strobe
  output logic      [15:0] cdat_o,  // Gain word
  output logic             clr_o,   // Status read
  output logic      [15:0] lim_o[4] // oc, ov, uv, op limits
);
  initial begin
    {swr_o, cwr_o, clr_o} = 3'h0;
    {sdat_o, cdat_o} = 32'h0;
    lim_o = '{16'h7fff, 16'h7fff, 16'h8000, 16'h7fff};
  end
  // Words go whole as 16-bit two's complement
  // Released data shows the inverse, never a stale copy
  task automatic put(input int k, input logic [15:0] d);
    @(negedge mclk_i);
    if (k == 0) {swr_o, sdat_o} = {1'b1, d};
    if (k == 1) {cwr_o, cdat_o} = {1'b1, d};
    clr_o = (k == 2);
    @(negedge mclk_i);
    {swr_o, cwr_o, clr_o} = 3'h0;
    {sdat_o, cdat_o} = {~sdat_o, ~cdat_o};
  endtask
  // Caller encodes limits in the direct-format coefficients
  task automatic limits(input logic [15:0] oc, ov, uv, op);
    @(negedge mclk_i);
    lim_o = '{oc, ov, uv, op};
  endtask
endmodule // sts_host
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [15:0] shunt_code_i = 16'h1234;
  logic [15:0] rail_code_i = 16'h0100;
  logic        setup_wr_i, cal_wr_i, ready_clr_i;
  logic [15:0] setup_data_i, cal_data_i, lim[4];
  logic [15:0] setup_o, cal_o, sense_drop_reading_o, rail_o, current_o, power_o;
  logic [31:0] energy_o;
  logic        ready_o, cal_loaded_o, busy_o, oc_warn_o, ov_warn_o, uv_warn_o, op_warn_o;
  int          n_fail = 0;
  int          checks_done = 0;
  int          n;

  always #5 mclk_i = ~mclk_i;

  sts_host i_sts_host (.mclk_i, .swr_o(setup_wr_i), .sdat_o(setup_data_i), .cwr_o(cal_wr_i),
    .cdat_o(cal_data_i), .clr_o(ready_clr_i), .lim_o(lim));

  // Short top time code keeps each set with both time codes at 7 near 1600 cycles
  sts_top #(.CT7_TICKS(4)) i_sts_top (.mclk_i, .rst_i, .shunt_code_i, .rail_code_i,
    .setup_wr_i, .setup_data_i, .cal_wr_i, .cal_data_i, .ready_clr_i, .oc_limit_i(lim[0]),
    .ov_limit_i(lim[1]), .uv_limit_i(lim[2]), .op_limit_i(lim[3]), .setup_o, .cal_o,
    .sense_drop_reading_o, .rail_o, .current_o, .power_o, .energy_o, .ready_o, .cal_loaded_o,
    .busy_o, .oc_warn_o, .ov_warn_o, .uv_warn_o, .op_warn_o);

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a load, then a status read that must clear ready
  task automatic wait_rdy(output int cnt);
    cnt = 0;
    while (ready_o !== 1'b1 && cnt < 20000) begin
      @(negedge mclk_i);
      cnt++;
    end
    if (ready_o !== 1'b1) begin
      n_fail++;
      results();
    end
    i_sts_host.put(2, 16'h0000);
    chk(ready_o, 1'b0);
  endtask

  function automatic logic [15:0] exp_pw(input logic signed [15:0] c, r);
    longint v;
    // Power step is 25 current steps, rail step 1.25 mV: divide by 20000
    v = (longint'(c) * longint'(r)) / 20000;
    return v[15:0];
  endfunction

  task automatic t_reset_nocal();
    chk({setup_o, cal_o}, {16'h4127, 16'h0001});
    chk({ready_o, cal_loaded_o}, 2'h0);
    i_sts_host.put(0, 16'h01ff);
    wait_rdy(n);
    chk({sense_drop_reading_o, rail_o}, {shunt_code_i, rail_code_i});
    chk({current_o, power_o}, 32'h0);
  endtask

  task automatic t_cal();
    i_sts_host.put(1, 16'h0800);
    i_sts_host.put(0, 16'h01ff);
    wait_rdy(n);
    chk(current_o, 16'h1234);
    chk(power_o, exp_pw(16'h1234, 16'h0100));
    chk(energy_o, {16'h0000, exp_pw(16'h1234, 16'h0100)});
  endtask

  task automatic t_sat();
    logic [15:0] codes[2] = '{16'h8000, 16'h7fff};
    i_sts_host.put(1, 16'h7fff);
    foreach (codes[k]) begin
      @(negedge mclk_i) shunt_code_i = codes[k];
      i_sts_host.put(0, 16'h01ff);
      wait_rdy(n);
      chk(current_o, codes[k]);
    end
  endtask

  task automatic t_warn();
    @(negedge mclk_i) shunt_code_i = 16'h1234;
    i_sts_host.put(1, 16'h0800);
    i_sts_host.put(0, 16'h01ff);
    wait_rdy(n);
    i_sts_host.limits(16'h123f, 16'h7fff, 16'h010f, 16'h7fff);
    repeat (3) @(negedge mclk_i);
    chk({oc_warn_o, ov_warn_o, uv_warn_o, op_warn_o}, 4'h0);
    i_sts_host.limits(16'h122f, 16'h00ff, 16'h0110, 16'h0000);
    repeat (3) @(negedge mclk_i);
    chk({oc_warn_o, ov_warn_o, uv_warn_o, op_warn_o}, 4'hf);
  endtask

  task automatic t_avg();
    i_sts_host.put(0, 16'h03ff);
    wait_rdy(n);
    chk(n > 4 * 1500, 1'b1);
    chk({sense_drop_reading_o, current_o}, {16'h1234, 16'h1234});
  endtask

  // Triggered mode gives one set per write, powerdown none
  task automatic t_trig();
    int k;
    i_sts_host.put(0, 16'h01fb);
    wait_rdy(n);
    k = 0;
    while (k < 4000 && ready_o !== 1'b1) begin
      @(negedge mclk_i);
      k++;
    end
    chk({ready_o, busy_o}, 2'h0);
    i_sts_host.put(0, 16'h01f8);
    k = 0;
    while (k < 4000 && ready_o !== 1'b1) begin
      @(negedge mclk_i);
      k++;
    end
    chk({setup_o, ready_o, busy_o}, {16'h01f8, 2'h0});
  endtask

  task automatic t_times();
    logic [15:0] cfg[2] = '{16'h003f, 16'h01c7};
    foreach (cfg[k]) begin
      i_sts_host.put(0, cfg[k]);
      wait_rdy(n);
      wait_rdy(n);
      chk(n > 72 * 200 && n < 76 * 200, 1'b1);
    end
  endtask

  initial begin
    repeat (16) @(negedge mclk_i);
    rst_i = 1'b0;
    @(negedge mclk_i);
    t_reset_nocal();
    t_cal();
    t_sat();
    t_warn();
    t_avg();
    t_trig();
    t_times();
    results();
  end
endmodule // testbench
`default_nettype wire
